// ### logic/rtc_alarm_tick.sv
`timescale 1ns/1ps

// What this block does
// R1: In 12-hour mode afternoon hours add two to tens digit, 17..23 become 25..31.
// R2: Day-of-week register at offset 0x018 resets to six, Saturday.
// R3: Time alarm holds BCD hours 21:16, minutes 14:8, seconds 6:0.
// R4: Calendar alarm holds BCD years 23:16, months 12:8, days 5:0.
// R5: Alarm values are stored unchecked; software must write valid BCD.
// R6: Bit 0 of the leap register reads one in a leap year.
// R7: Enable bit 1 turns on both the tick counter and its interrupt.
// R8: Enable bit 0 gates the alarm interrupt.
// R9: Each tick sets status bit 1, held until software clears it.
// R10: Alarm match of time and calendar sets status bit 0 and raises interrupt when enable bit 0 is set.
// R11: Software clears each status flag on its own through the register port.
// R12: Tick select code 0 gives one second, each step halves, code 5 is 1/32.
// R13: Codes 6 and 7 give 1/64 and 1/128 second.
// R14: A written value takes effect on the second RTC clock step after the write, one to two RTC periods later.
// R15: Register access only while the password-set access flag is raised.
// R16: Format bit one is 24-hour; zero is 12-hour, midnight 12, noon 32.
module rtc_alarm_tick
	import rtc_alarm_pkg::*;
#(
	parameter int unsigned RTC_DIV = RTC_DIV_DEF
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Register port
	input  wire reg_req_t   i_req,
	output logic [31:0]     o_rdata,
	// Shared state from the time and calendar counters
	input  wire time_bcd_t  i_cur_time,
	input  wire date_bcd_t  i_cur_date,
	input  wire logic       i_hour_24,
	input  wire logic       i_access_granted,
	// Results
	output logic            o_irq,
	output logic [2:0]      o_day_of_week
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_r;
	logic rstn;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_r <= 1'b0;
			rstn       <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rstn       <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// RTC rate enable
	// ----------------------------------------
	logic [15:0] div_cnt_r;
	logic        rtc_en_r;

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_r <= 16'h0000;
			rtc_en_r  <= 1'b0;
		end else if (div_cnt_r == 16'(RTC_DIV - 1)) begin
			div_cnt_r <= 16'h0000;
			rtc_en_r  <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
			rtc_en_r  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	logic  wr_ok;
	logic  rd_ok;
	cfg_t  cfg_w_r;
	cfg_t  cfg_s1_r;
	cfg_t  cfg_r;
	localparam cfg_t CFG_RESET = '{day_of_week: DOW_RESET, default: '0};

	assign wr_ok = i_req.wr && i_access_granted; // see R15
	assign rd_ok = i_req.rd && i_access_granted; // see R15

	// Values stored as written, no range check, see R5
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_w_r <= CFG_RESET; // see R2
		end else if (wr_ok) begin
			case (i_req.addr)
				OFF_DAY_OF_WEEK:    cfg_w_r.day_of_week <= i_req.wdata[2:0];
				OFF_TIME_ALARM:     cfg_w_r.time_alarm <= word_to_time(i_req.wdata); // see R3
				OFF_CALENDAR_ALARM: cfg_w_r.calendar_alarm <= word_to_date(i_req.wdata); // see R4
				OFF_IRQ_ENABLE:     cfg_w_r.irq_enable <= i_req.wdata[1:0];
				OFF_PERIODIC_SEL:   cfg_w_r.periodic_interval_select <= i_req.wdata[2:0];
				default: begin
				end
			endcase
		end
	end

	// Two RTC-rate stages, so the slow logic never sees a half-written value
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_s1_r <= CFG_RESET;
			cfg_r    <= CFG_RESET;
		end else if (rtc_en_r) begin
			cfg_s1_r <= cfg_w_r; // see R14
			cfg_r    <= cfg_s1_r; // see R14
		end
	end

	// ----------------------------------------
	// Periodic tick
	// ----------------------------------------
	logic [15:0] tick_cnt_r;
	logic [15:0] tick_span;
	logic        tick_evt;

	// Span in RTC periods: 32768 shifted down by the select code
	assign tick_span = TICK_BASE >> cfg_r.periodic_interval_select; // see R12 see R13
	assign tick_evt  = rtc_en_r && cfg_r.irq_enable.periodic_pulse_flag &&
		(tick_cnt_r == tick_span - 16'h0001); // see R7

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_r <= 16'h0000;
		end else if (!cfg_r.irq_enable.periodic_pulse_flag) begin
			tick_cnt_r <= 16'h0000; // see R7
		end else if (rtc_en_r) begin
			tick_cnt_r <= tick_evt ? 16'h0000 : tick_cnt_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// Alarm compare
	// ----------------------------------------
	logic [5:0] hour_12;
	time_bcd_t  cur_cmp;
	logic       match;
	logic       match_q_r;
	logic       alarm_evt;
	logic [4:0] hour_bin;
	logic [4:0] pm_bin;

	// Counters run in 24-hour BCD; the alarm is kept in the selected format
	always_comb begin
		hour_bin = 5'({i_cur_time.tens_of_hours, 3'h0}) + 5'({i_cur_time.tens_of_hours, 1'h0}) +
			5'(i_cur_time.unit_hours);
		pm_bin   = hour_bin - 5'h0c;
		if (hour_bin == 5'h00) begin
			hour_12 = 6'h12; // see R16
		end else if (hour_bin < 5'h0c) begin
			hour_12 = {i_cur_time.tens_of_hours, i_cur_time.unit_hours};
		end else if (hour_bin == 5'h0c) begin
			hour_12 = 6'h32; // see R16
		end else if (pm_bin >= 5'h0a) begin
			hour_12 = {2'h3, 4'(pm_bin - 5'h0a)}; // see R1
		end else begin
			hour_12 = {2'h2, pm_bin[3:0]}; // see R1
		end
		cur_cmp = i_cur_time;
		if (!i_hour_24) begin
			{cur_cmp.tens_of_hours, cur_cmp.unit_hours} = hour_12; // see R16
		end
	end

	assign match     = (cur_cmp == cfg_r.time_alarm) && (i_cur_date == cfg_r.calendar_alarm); // see R10
	assign alarm_evt = rtc_en_r && match && !match_q_r;

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			match_q_r <= 1'b0;
		end else if (rtc_en_r) begin
			match_q_r <= match;
		end
	end

	// ----------------------------------------
	// Leap year
	// ----------------------------------------
	logic leap_r;

	// Years are 20xY; 2000 counts as leap
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			leap_r <= 1'b0;
		end else if (i_cur_date.tens_of_years[0]) begin
			leap_r <= (i_cur_date.unit_years == 4'h2) || (i_cur_date.unit_years == 4'h6); // see R6
		end else begin
			leap_r <= (i_cur_date.unit_years == 4'h0) || (i_cur_date.unit_years == 4'h4) ||
				(i_cur_date.unit_years == 4'h8); // see R6
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	irq_bits_t status_r;
	irq_bits_t status_clr;
	irq_bits_t status_set;

	assign status_clr = (wr_ok && i_req.addr == OFF_IRQ_STATUS) ? i_req.wdata[1:0] : 2'h0; // see R11
	assign status_set = {tick_evt, alarm_evt};

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			status_r <= 2'h0;
		end else begin
			status_r <= (status_r & ~status_clr) | status_set; // see R9 see R10 see R11
		end
	end

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_r & cfg_r.irq_enable); // see R7 see R8
		end
	end

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			o_day_of_week <= DOW_RESET;
		end else begin
			o_day_of_week <= cfg_r.day_of_week;
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	logic [31:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (rd_ok) begin
			case (i_req.addr)
				OFF_DAY_OF_WEEK:    rdata_nxt = {29'h0, cfg_w_r.day_of_week};
				OFF_TIME_ALARM:     rdata_nxt = time_to_word(cfg_w_r.time_alarm);
				OFF_CALENDAR_ALARM: rdata_nxt = date_to_word(cfg_w_r.calendar_alarm);
				OFF_LEAP_YEAR_FLAG: rdata_nxt = {31'h0, leap_r}; // see R6
				OFF_IRQ_ENABLE:     rdata_nxt = {30'h0, cfg_w_r.irq_enable};
				OFF_IRQ_STATUS:     rdata_nxt = {30'h0, status_r};
				OFF_PERIODIC_SEL:   rdata_nxt = {29'h0, cfg_w_r.periodic_interval_select};
				default:            rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_clear_alarm;
		wr_ok && i_req.addr == OFF_IRQ_STATUS && i_req.wdata[0] && !alarm_evt;
	endsequence

	// Counts RTC steps since the last bus write; the range of cycles is too wide for a delay range
	logic [1:0] settle_cnt_r;

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			settle_cnt_r <= 2'h0;
		end else if (wr_ok) begin
			settle_cnt_r <= 2'h0;
		end else if (rtc_en_r && settle_cnt_r != 2'h2) begin
			settle_cnt_r <= settle_cnt_r + 2'h1;
		end
	end

	sequence s_two_rtc_steps;
		settle_cnt_r == 2'h2;
	endsequence

	property p_clear_alarm;
		@(posedge i_clk) disable iff (!rstn)
		s_clear_alarm |=> !status_r.alarm_hit_flag;
	endproperty
	a_clear_alarm: assert property (p_clear_alarm) else $error("alarm flag not cleared"); // see R11

	property p_tick_sets;
		@(posedge i_clk) disable iff (!rstn)
		tick_evt |=> status_r.periodic_pulse_flag;
	endproperty
	a_tick_sets: assert property (p_tick_sets) else $error("tick flag not set"); // see R9

	property p_alarm_sets;
		@(posedge i_clk) disable iff (!rstn)
		alarm_evt |=> status_r.alarm_hit_flag ##1 (o_irq == cfg_r.irq_enable.alarm_hit_flag || status_r[1]);
	endproperty
	a_alarm_sets: assert property (p_alarm_sets) else $error("alarm flag or irq missing"); // see R10

	property p_tick_off;
		@(posedge i_clk) disable iff (!rstn)
		!cfg_r.irq_enable.periodic_pulse_flag |-> !tick_evt ##1 tick_cnt_r == 16'h0000;
	endproperty
	a_tick_off: assert property (p_tick_off) else $error("tick ran while disabled"); // see R7

	property p_alarm_gate;
		@(posedge i_clk) disable iff (!rstn)
		(!cfg_r.irq_enable.alarm_hit_flag && !(status_r[1] && cfg_r.irq_enable[1])) |=> !o_irq;
	endproperty
	a_alarm_gate: assert property (p_alarm_gate) else $error("irq raised while gated"); // see R8

	property p_tick_span;
		@(posedge i_clk) disable iff (!rstn)
		tick_evt |-> tick_cnt_r == (16'h7fff >> cfg_r.periodic_interval_select);
	endproperty
	a_tick_span: assert property (p_tick_span) else $error("tick interval wrong"); // see R12

	property p_denied_write;
		@(posedge i_clk) disable iff (!rstn)
		i_req.wr && !i_access_granted |=> $stable(cfg_w_r);
	endproperty
	a_denied_write: assert property (p_denied_write) else $error("write taken without access"); // see R15

	property p_staged;
		@(posedge i_clk) disable iff (!rstn)
		rtc_en_r |=> cfg_r == $past(cfg_s1_r) && cfg_s1_r == $past(cfg_w_r);
	endproperty
	a_staged: assert property (p_staged) else $error("config not staged"); // see R14

	property p_settle;
		@(posedge i_clk) disable iff (!rstn)
		s_two_rtc_steps |-> cfg_r == cfg_w_r;
	endproperty
	a_settle: assert property (p_settle) else $error("config not settled"); // see R14

	property p_pm_hour;
		@(posedge i_clk) disable iff (!rstn)
		!i_hour_24 && i_cur_time.tens_of_hours == 2'h1 && i_cur_time.unit_hours == 4'h7 |->
			hour_12 == 6'h25 && {cur_cmp.tens_of_hours, cur_cmp.unit_hours} == 6'h25;
	endproperty
	a_pm_hour: assert property (p_pm_hour) else $error("12-hour afternoon encoding wrong"); // see R1

endmodule

// ### logic/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_DAY_OF_WEEK    = 8'h18;
	localparam logic [7:0] OFF_TIME_ALARM     = 8'h1c;
	localparam logic [7:0] OFF_CALENDAR_ALARM = 8'h20;
	localparam logic [7:0] OFF_LEAP_YEAR_FLAG = 8'h24;
	localparam logic [7:0] OFF_IRQ_ENABLE     = 8'h28;
	localparam logic [7:0] OFF_IRQ_STATUS     = 8'h2c;
	localparam logic [7:0] OFF_PERIODIC_SEL   = 8'h30;

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [2:0] DOW_RESET       = 3'h6;
	localparam int         TENS_HOURS_LSB  = 20;
	localparam int         UNIT_HOURS_LSB  = 16;
	localparam int         TENS_MIN_LSB    = 12;
	localparam int         UNIT_MIN_LSB    = 8;
	localparam int         TENS_SEC_LSB    = 4;
	localparam int         UNIT_SEC_LSB    = 0;
	localparam int         TENS_YEARS_LSB  = 20;
	localparam int         UNIT_YEARS_LSB  = 16;
	localparam int         TENS_MONTHS_LSB = 12;
	localparam int         UNIT_MONTHS_LSB = 8;
	localparam int         TENS_DAYS_LSB   = 4;
	localparam int         UNIT_DAYS_LSB   = 0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ      = 200000000;
	localparam int unsigned RTC_HZ      = 32768;
	localparam int unsigned RTC_DIV_DEF = CLK_HZ / RTC_HZ;
	localparam logic [15:0] TICK_BASE   = 16'h8000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic [1:0] tens_of_hours;
		logic [3:0] unit_hours;
		logic [2:0] tens_of_minutes;
		logic [3:0] unit_minutes;
		logic [2:0] tens_of_seconds;
		logic [3:0] unit_seconds;
	} time_bcd_t;

	typedef struct packed {
		logic [3:0] tens_of_years;
		logic [3:0] unit_years;
		logic       tens_of_months;
		logic [3:0] unit_months;
		logic [1:0] tens_of_days;
		logic [3:0] unit_days;
	} date_bcd_t;

	typedef struct packed {
		logic periodic_pulse_flag;
		logic alarm_hit_flag;
	} irq_bits_t;

	typedef struct packed {
		logic [2:0] day_of_week;
		time_bcd_t  time_alarm;
		date_bcd_t  calendar_alarm;
		irq_bits_t  irq_enable;
		logic [2:0] periodic_interval_select;
	} cfg_t;

	// ----------------------------------------
	// Field packing
	// ----------------------------------------
	function automatic time_bcd_t word_to_time(input logic [31:0] w);
		word_to_time = {w[TENS_HOURS_LSB+:2], w[UNIT_HOURS_LSB+:4], w[TENS_MIN_LSB+:3],
			w[UNIT_MIN_LSB+:4], w[TENS_SEC_LSB+:3], w[UNIT_SEC_LSB+:4]};
	endfunction

	function automatic logic [31:0] time_to_word(input time_bcd_t t);
		time_to_word = {10'h000, t.tens_of_hours, t.unit_hours, 1'b0, t.tens_of_minutes,
			t.unit_minutes, 1'b0, t.tens_of_seconds, t.unit_seconds};
	endfunction

	function automatic date_bcd_t word_to_date(input logic [31:0] w);
		word_to_date = {w[TENS_YEARS_LSB+:4], w[UNIT_YEARS_LSB+:4], w[TENS_MONTHS_LSB],
			w[UNIT_MONTHS_LSB+:4], w[TENS_DAYS_LSB+:2], w[UNIT_DAYS_LSB+:4]};
	endfunction

	function automatic logic [31:0] date_to_word(input date_bcd_t d);
		date_to_word = {8'h00, d.tens_of_years, d.unit_years, 3'h0, d.tens_of_months,
			d.unit_months, 2'h0, d.tens_of_days, d.unit_days};
	endfunction

endpackage

// ### dv/rtc_alarm_tick_tb_top.sv
`timescale 1ns/1ps
module rtc_alarm_tick_tb_top;
	import rtc_alarm_pkg::*;

	// ----------------------------------------
	// Bench signals
	// ----------------------------------------
	// Small divider keeps tick periods within a short run
	localparam int unsigned DIV = 4;
	logic        i_clk;
	logic        i_rstn;
	reg_req_t    i_req;
	logic [31:0] o_rdata;
	time_bcd_t   i_cur_time;
	date_bcd_t   i_cur_date;
	logic        i_hour_24;
	logic        i_access_granted;
	logic        o_irq;
	logic [2:0]  o_day_of_week;
	int          n_mismatch;
	int          n_checks;
	logic [31:0] rd_val;

	rtc_alarm_tick #(.RTC_DIV(DIV)) u_dut (
		.i_clk            (i_clk),
		.i_rstn           (i_rstn),
		.i_req            (i_req),
		.o_rdata          (o_rdata),
		.i_cur_time       (i_cur_time),
		.i_cur_date       (i_cur_date),
		.i_hour_24        (i_hour_24),
		.i_access_granted (i_access_granted),
		.o_irq            (o_irq),
		.o_day_of_week    (o_day_of_week)
	);

	always #2.5 i_clk = ~i_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		i_req.wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a);
		@(posedge i_clk);
		i_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		i_req.rd <= 1'b0;
		#1 rd_val = o_rdata;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus_rd(a);
		chk(name, exp, rd_val);
	endtask

	// Bounded wait for the interrupt line; cnt counts the cycles spent
	task automatic wait_irq(input int bound, output int cnt);
		for (cnt = 0; cnt < bound; cnt++) begin
			@(posedge i_clk);
			if (o_irq === 1'b1) begin
				return;
			end
		end
		n_mismatch++;
		$display("Error irq wait expected 1 seen timeout");
		end_of_test();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_reset_values();
		chk("dow out", 32'h6, {29'h0, o_day_of_week});
		chk("irq out", 32'h0, {31'h0, o_irq});
		rd_chk("dow", OFF_DAY_OF_WEEK, 32'h0000_0006);
		rd_chk("time_alarm", OFF_TIME_ALARM, 32'h0);
		rd_chk("calendar_alarm", OFF_CALENDAR_ALARM, 32'h0);
		rd_chk("irq_enable", OFF_IRQ_ENABLE, 32'h0);
		rd_chk("irq_status", OFF_IRQ_STATUS, 32'h0);
		rd_chk("periodic_sel", OFF_PERIODIC_SEL, 32'h0);
		rd_chk("unmapped", 8'h34, 32'h0);
	endtask

	// Unchecked storage: every alarm field at its widest, reserved bits dropped
	task automatic sc_fields();
		bus_wr(OFF_TIME_ALARM, 32'hffff_ffff);
		rd_chk("time_alarm all", OFF_TIME_ALARM, 32'h003f_7f7f);
		bus_wr(OFF_CALENDAR_ALARM, 32'hffff_ffff);
		rd_chk("calendar_alarm all", OFF_CALENDAR_ALARM, 32'h00ff_1f3f);
		bus_wr(OFF_LEAP_YEAR_FLAG, 32'hffff_ffff);
		rd_chk("leap ro", OFF_LEAP_YEAR_FLAG, 32'h0000_0001);
		bus_wr(OFF_DAY_OF_WEEK, 32'h0000_0003);
		idle(1);
		chk("dow early", 32'h6, {29'h0, o_day_of_week});
		idle(12);
		chk("dow late", 32'h3, {29'h0, o_day_of_week});
		i_access_granted <= 1'b0;
		bus_wr(OFF_DAY_OF_WEEK, 32'h0000_0005);
		rd_chk("dow locked", OFF_DAY_OF_WEEK, 32'h0);
		i_access_granted <= 1'b1;
		rd_chk("dow kept", OFF_DAY_OF_WEEK, 32'h3);
	endtask

	task automatic sc_leap();
		i_cur_date.unit_years <= 4'h3;
		rd_chk("leap 23", OFF_LEAP_YEAR_FLAG, 32'h0);
		i_cur_date.tens_of_years <= 4'h0;
		i_cur_date.unit_years <= 4'h0;
		rd_chk("leap 00", OFF_LEAP_YEAR_FLAG, 32'h1);
		i_cur_date <= '{4'h2, 4'h4, 1'b0, 4'h5, 2'h1, 4'h2};
		rd_chk("leap 24", OFF_LEAP_YEAR_FLAG, 32'h1);
	endtask

	// Measure a whole tick interval after a clear, so a code change mid-count does not matter
	task automatic sc_tick();
		int p;
		int cnt;
		for (int code = 5; code <= 7; code++) begin
			p = DIV * (32768 >> code);
			bus_wr(OFF_PERIODIC_SEL, 32'(code));
			bus_wr(OFF_IRQ_ENABLE, 32'h2);
			wait_irq(2 * p + 100, cnt);
			bus_wr(OFF_IRQ_STATUS, 32'h2);
			// Let the cleared flag reach the irq line before timing the next tick
			idle(2);
			wait_irq(p + 50, cnt);
			chk("tick short", 32'h1, {31'h0, cnt >= p - 3 * DIV - 8});
			rd_chk("tick flag", OFF_IRQ_STATUS, 32'h2);
			bus_wr(OFF_IRQ_ENABLE, 32'h0);
			idle(12);
			bus_wr(OFF_IRQ_STATUS, 32'h2);
			idle(2);
			chk("irq clear", 32'h0, {31'h0, o_irq});
		end
	endtask

	task automatic sc_alarm();
		int cnt;
		i_hour_24 <= 1'b0;
		i_cur_time <= '{2'h1, 4'h6, 3'h5, 4'h9, 3'h5, 4'h9};
		bus_wr(OFF_TIME_ALARM, 32'h0025_0000);
		bus_wr(OFF_CALENDAR_ALARM, 32'h0024_0512);
		bus_wr(OFF_PERIODIC_SEL, 32'h7);
		idle(12);
		rd_chk("no early alarm", OFF_IRQ_STATUS, 32'h0);
		i_cur_time <= '{2'h1, 4'h7, 3'h0, 4'h0, 3'h0, 4'h0};
		idle(20);
		rd_chk("alarm flag", OFF_IRQ_STATUS, 32'h1);
		chk("alarm masked", 32'h0, {31'h0, o_irq});
		idle(1100);
		rd_chk("tick off", OFF_IRQ_STATUS, 32'h1);
		bus_wr(OFF_IRQ_ENABLE, 32'h1);
		wait_irq(20, cnt);
		bus_wr(OFF_IRQ_ENABLE, 32'h2);
		// Old alarm enable still acts until the new value settles
		idle(12);
		chk("alarm regated", 32'h0, {31'h0, o_irq});
		wait_irq(2200, cnt);
		bus_wr(OFF_IRQ_ENABLE, 32'h0);
		idle(12);
		rd_chk("both flags", OFF_IRQ_STATUS, 32'h3);
		bus_wr(OFF_IRQ_STATUS, 32'h1);
		rd_chk("alarm cleared", OFF_IRQ_STATUS, 32'h2);
		bus_wr(OFF_IRQ_STATUS, 32'h2);
		rd_chk("tick cleared", OFF_IRQ_STATUS, 32'h0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		i_rstn = 1'b0;
		i_req = '0;
		i_cur_time = '{2'h0, 4'h0, 3'h0, 4'h0, 3'h0, 4'h0};
		i_cur_date = '{4'h2, 4'h4, 1'b0, 4'h5, 2'h1, 4'h2};
		i_hour_24 = 1'b1;
		i_access_granted = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		idle(3);
		i_rstn <= 1'b1;
		idle(3);
		sc_reset_values();
		sc_fields();
		sc_leap();
		sc_tick();
		sc_alarm();
		end_of_test();
	end

endmodule
